// >>> hdl/tcc_channel.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_channel
    import tcc_pkg::*;
(
    input  wire logic       aclk,      // Bus clock
    input  wire logic       aresetn,   // Sync reset, active low
    input  wire logic       is_output, // Output compare selected
    input  wire logic [1:0] els,       // Edge or action select
    input  wire logic       tov,       // Toggle on overflow
    input  wire logic       overflow,  // Counter wraps this cycle
    input  wire logic       match,     // Counter reaches compare value
    input  wire logic       pin_in,    // Pin level
    output logic            event_p,   // Capture or compare pulse
    output logic            pin_out,   // Driven pin level
    output logic            pin_oe     // Timer drives the pin
);

    tcc_ch_st_t st;
    tcc_ch_st_t next_st;
    logic       rise;
    logic       fall;

    always_comb begin
        next_st          = st;
        rise             = pin_in & ~st.pin_prev;
        fall             = ~pin_in & st.pin_prev;
        next_st.pin_prev = pin_in;
        event_p          = 1'b0;
        if (is_output) begin
            // Compare after toggle, so a compare at zero still forces its level
            if (overflow && tov) begin
                next_st.level = ~st.level;
            end
            if (match) begin
                event_p = 1'b1;
                case (els)
                    `TCC_ELS_TOGGLE: next_st.level = ~next_st.level;
                    `TCC_ELS_CLEAR:  next_st.level = 1'b0;
                    `TCC_ELS_SET:    next_st.level = 1'b1;
                    default:         next_st.level = next_st.level;
                endcase
            end
        end else begin
            event_p = (els[0] & rise) | (els[1] & fall);
        end
    end

    assign pin_out = st.level;
    assign pin_oe  = is_output & (els != `TCC_ELS_OFF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tcc_channel

// >>> hdl/tcc_pkg.sv
package tcc_pkg;

    typedef struct packed {
        logic       flag;
        logic       ie;
        logic       link;
        logic       msa;
        logic [1:0] els;
        logic       tov;
    } tcc_chctl_t;

    typedef struct packed {
        logic [5:0] div;
        logic       ext_prev;
    } tcc_pre_st_t;

    typedef struct packed {
        logic pin_prev;
        logic level;
    } tcc_ch_st_t;

    typedef struct packed {
        logic [2:0]        aw_idx;
        logic              aw_bad;
        logic              aw_full;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              w_full;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [15:0]       count;
        logic [15:0]       modulo;
        logic              ovf_flag;
        logic              ovf_ie;
        logic              stop;
        logic [2:0]        ps;
        tcc_chctl_t [1:0]  ch;
        logic [1:0][15:0]  val;
        logic              last_wr;
        logic              active;
    } tcc_st_t;

endpackage : tcc_pkg

// >>> hdl/tcc_prescaler.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_prescaler
    import tcc_pkg::*;
(
    input  wire logic       aclk,     // Bus clock
    input  wire logic       aresetn,  // Sync reset, active low
    input  wire logic       clear,    // Restart the divider
    input  wire logic       run,      // Counting allowed
    input  wire logic [2:0] sel,      // Rate select
    input  wire logic       ext_clk,  // External clock pin level
    output logic            tick      // Counter advance pulse
);

    tcc_pre_st_t st;
    tcc_pre_st_t next_st;
    logic [5:0]  mask;

    always_comb begin
        next_st          = st;
        mask             = 6'((7'h1 << sel) - 7'h1);
        next_st.ext_prev = ext_clk;
        if (sel == `TCC_PS_EXT) begin
            tick = run & ext_clk & ~st.ext_prev;
        end else begin
            tick = run & ((st.div & mask) == mask);
        end
        if (clear) begin
            next_st.div = 6'h00;
        end else if (run) begin
            next_st.div = 6'(st.div + 6'h01);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tcc_prescaler

// >>> hdl/tcc_regs.svh
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define TCC_IDX_CTRL    3'h0
`define TCC_IDX_COUNT   3'h1
`define TCC_IDX_MOD     3'h2
`define TCC_IDX_CH0CTL  3'h3
`define TCC_IDX_CH0VAL  3'h4
`define TCC_IDX_CH1CTL  3'h5
`define TCC_IDX_CH1VAL  3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCC_B_FLAG      7
`define TCC_B_IE        6
`define TCC_B_STOP      5
`define TCC_B_RST       4
`define TCC_B_LINK      5
`define TCC_B_MSA       4
`define TCC_B_ELS_HI    3
`define TCC_B_ELS_LO    2
`define TCC_B_TOV       1

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define TCC_ELS_OFF     2'h0
`define TCC_ELS_TOGGLE  2'h1
`define TCC_ELS_CLEAR   2'h2
`define TCC_ELS_SET     2'h3
`define TCC_PS_EXT      3'h7
`define TCC_RST_MOD     16'hffff
`define TCC_RST_STOP    1'b1
`define TCC_RESP_OK     2'h0
`define TCC_RESP_ERR    2'h2

`endif

// >>> hdl/tcc_top.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_top
    import tcc_pkg::*;
(
    input  wire logic        aclk,                      // Bus clock
    input  wire logic        aresetn,                   // Sync reset, active low
    input  wire logic [7:0]  s_axi_awaddr,              // Write address
    input  wire logic        s_axi_awvalid,             // Write address valid
    output logic             s_axi_awready,             // Write address ready
    input  wire logic [31:0] s_axi_wdata,               // Write data
    input  wire logic [3:0]  s_axi_wstrb,               // Write byte lanes
    input  wire logic        s_axi_wvalid,              // Write data valid
    output logic             s_axi_wready,              // Write data ready
    output logic [1:0]       s_axi_bresp,               // Write response
    output logic             s_axi_bvalid,              // Write response valid
    input  wire logic        s_axi_bready,              // Write response ready
    input  wire logic [7:0]  s_axi_araddr,              // Read address
    input  wire logic        s_axi_arvalid,             // Read address valid
    output logic             s_axi_arready,             // Read address ready
    output logic [31:0]      s_axi_rdata,               // Read data
    output logic [1:0]       s_axi_rresp,               // Read response
    output logic             s_axi_rvalid,              // Read data valid
    input  wire logic        s_axi_rready,              // Read data ready
    input  wire logic        chan0_pin_in,              // Channel 0 pin level
    output logic             chan0_pin_out,             // Channel 0 pin drive
    output logic             chan0_pin_oe,              // Channel 0 pin enable
    input  wire logic        chan1_pin_in,              // Channel 1 pin level
    output logic             chan1_pin_out,             // Channel 1 pin drive
    output logic             chan1_pin_oe,              // Channel 1 pin enable
    input  wire logic        external_timer_clock_pin,  // External count clock
    input  wire logic        break_state,               // Processor in break
    output logic             overflow_irq,              // Overflow request
    output logic             chan0_irq,                 // Channel 0 request
    output logic             chan1_irq                  // Channel 1 request
);

    tcc_st_t     st;
    tcc_st_t     next_st;
    logic        tick;
    logic        run;
    logic        pre_clear;
    logic        overflow;
    logic [15:0] next_count;
    logic        linked;
    logic [15:0] cmp0;
    logic [1:0]  match;
    logic [1:0]  is_out;
    logic [1:0]  ev;
    logic        do_write;
    logic [31:0] rd_data;
    logic        rd_ok;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] s);
        merge16 = {s[1] ? wd[15:8] : old[15:8], s[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // ----------------------------------------
    // Counter and channel wiring
    // ----------------------------------------
    assign run        = ~st.stop & ~break_state;
    assign overflow   = tick & (st.count == st.modulo);
    assign next_count = (st.count == st.modulo) ? 16'h0000 : 16'(st.count + 16'h0001);
    assign linked     = st.ch[0].link;
    // Linked pair: whichever set is active drives channel 0
    assign cmp0       = (linked && st.active) ? st.val[1] : st.val[0];
    assign match[0]   = tick & (next_count == cmp0);
    assign match[1]   = tick & (next_count == st.val[1]);
    assign is_out[0]  = linked | st.ch[0].msa;
    assign is_out[1]  = ~linked & st.ch[1].msa;

    tcc_prescaler u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (pre_clear),
        .run     (run),
        .sel     (st.ps),
        .ext_clk (external_timer_clock_pin),
        .tick    (tick)
    );

    tcc_channel u_ch0 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .is_output (is_out[0]),
        .els       (st.ch[0].els),
        .tov       (st.ch[0].tov),
        .overflow  (overflow),
        .match     (match[0]),
        .pin_in    (chan0_pin_in),
        .event_p   (ev[0]),
        .pin_out   (chan0_pin_out),
        .pin_oe    (chan0_pin_oe)
    );

    // Channel 1 goes idle while linked, leaving its pin to port logic
    tcc_channel u_ch1 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .is_output (is_out[1]),
        .els       (linked ? `TCC_ELS_OFF : st.ch[1].els),
        .tov       (st.ch[1].tov & ~linked),
        .overflow  (overflow),
        .match     (match[1] & ~linked),
        .pin_in    (chan1_pin_in),
        .event_p   (ev[1]),
        .pin_out   (chan1_pin_out),
        .pin_oe    (chan1_pin_oe)
    );

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    assign s_axi_awready = ~st.aw_full & ~st.bvalid;
    assign s_axi_wready  = ~st.w_full & ~st.bvalid;
    assign s_axi_arready = ~st.rvalid;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign do_write      = st.aw_full & st.w_full & ~st.bvalid;
    assign pre_clear     = do_write & (st.aw_idx == `TCC_IDX_CTRL) & ~st.aw_bad
                           & st.wstrb[0] & st.wdata[`TCC_B_RST];

    always_comb begin
        rd_ok   = (s_axi_araddr[7:5] == 3'h0);
        rd_data = 32'h0000_0000;
        case (s_axi_araddr[4:2])
            `TCC_IDX_CTRL:   rd_data = {24'h000000, st.ovf_flag, st.ovf_ie, st.stop, 2'b00, st.ps};
            `TCC_IDX_COUNT:  rd_data = {16'h0000, st.count};
            `TCC_IDX_MOD:    rd_data = {16'h0000, st.modulo};
            `TCC_IDX_CH0CTL: rd_data = {24'h000000, st.ch[0], 1'b0};
            `TCC_IDX_CH0VAL: rd_data = {16'h0000, st.val[0]};
            `TCC_IDX_CH1CTL: rd_data = {24'h000000, st.ch[1], 1'b0};
            `TCC_IDX_CH1VAL: rd_data = {16'h0000, st.val[1]};
            default:         rd_ok   = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_idx  = s_axi_awaddr[4:2];
            next_st.aw_bad  = (s_axi_awaddr[7:5] != 3'h0) || (s_axi_awaddr[4:2] == 3'h7);
            next_st.aw_full = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
            next_st.w_full = 1'b1;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_data;
            next_st.rresp  = rd_ok ? `TCC_RESP_OK : `TCC_RESP_ERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        if (tick) begin
            next_st.count = next_count;
        end
        if (!linked) begin
            next_st.active  = 1'b0;
            next_st.last_wr = 1'b0;
        end

        if (do_write) begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = st.aw_bad ? `TCC_RESP_ERR : `TCC_RESP_OK;
            if (!st.aw_bad) begin
                case (st.aw_idx)
                    `TCC_IDX_CTRL: begin
                        if (st.wstrb[0]) begin
                            next_st.ovf_flag = st.ovf_flag & ~st.wdata[`TCC_B_FLAG];
                            next_st.ovf_ie   = st.wdata[`TCC_B_IE];
                            next_st.stop     = st.wdata[`TCC_B_STOP];
                            next_st.ps       = st.wdata[2:0];
                            if (st.wdata[`TCC_B_RST]) begin
                                next_st.count = 16'h0000;
                            end
                        end
                    end
                    `TCC_IDX_MOD: begin
                        next_st.modulo = merge16(st.modulo, st.wdata, st.wstrb);
                    end
                    `TCC_IDX_CH0CTL, `TCC_IDX_CH1CTL: begin
                        if (st.wstrb[0]) begin
                            // Word 3 is channel 0, word 5 channel 1: bit 2 tells them apart
                            next_st.ch[st.aw_idx[2]] = {st.ch[st.aw_idx[2]].flag & ~st.wdata[`TCC_B_FLAG],
                                                        st.wdata[`TCC_B_IE:`TCC_B_TOV]};
                        end
                    end
                    `TCC_IDX_CH0VAL: begin
                        next_st.val[0]  = merge16(st.val[0], st.wdata, st.wstrb);
                        next_st.last_wr = 1'b0;
                    end
                    `TCC_IDX_CH1VAL: begin
                        next_st.val[1]  = merge16(st.val[1], st.wdata, st.wstrb);
                        next_st.last_wr = linked;
                    end
                    default: begin
                        next_st.bresp = `TCC_RESP_OK;
                    end
                endcase
            end
        end

        // Hardware sets come last so they win over a same-cycle clear
        if (overflow) begin
            next_st.ovf_flag = 1'b1;
            if (linked) begin
                next_st.active = next_st.last_wr;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (ev[i]) begin
                next_st.ch[i].flag = 1'b1;
                if (!is_out[i]) begin
                    next_st.val[i] = st.count;
                end
            end
        end
    end

    assign overflow_irq = st.ovf_flag & st.ovf_ie;
    assign chan0_irq    = st.ch[0].flag & st.ch[0].ie;
    assign chan1_irq    = st.ch[1].flag & st.ch[1].ie & ~linked;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st        <= '0;
            st.modulo <= `TCC_RST_MOD;
            st.stop   <= `TCC_RST_STOP;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_ovf_flag_set: assert property (overflow |=> st.ovf_flag)
        else $error("overflow flag not set");
    chk_count_wrap: assert property (overflow && !pre_clear |=> st.count == 16'h0000)
        else $error("counter did not wrap to zero");
    chk_count_step: assert property (tick && !overflow && !pre_clear
                                     |=> st.count == $past(st.count) + 16'h0001)
        else $error("counter did not step by one");
    chk_halt_hold: assert property (!run && !pre_clear |=> $stable(st.count))
        else $error("counter moved while halted");
    chk_rate_full: assert property (run && st.ps == 3'h0 |-> tick)
        else $error("rate 000 missed a tick");
    chk_capture_copy: assert property (ev[1] && !is_out[1] |=> st.val[1] == $past(st.count))
        else $error("capture value wrong");
    chk_flag_event: assert property (ev[1] |=> st.ch[1].flag)
        else $error("channel flag not set");
    chk_ovf_irq: assert property (overflow && st.ovf_ie && !do_write |=> overflow_irq)
        else $error("overflow request missing");
    chk_link_free: assert property (linked |-> !chan1_pin_oe && !chan1_irq)
        else $error("channel 1 active while linked");
    chk_cmp_set: assert property (match[0] && is_out[0] && st.ch[0].els == `TCC_ELS_SET
                                  |=> chan0_pin_out)
        else $error("compare set action missing");
    chk_write_resp: assert property (do_write |=> s_axi_bvalid ##0 s_axi_bresp == $past(st.aw_bad ? 2'h2 : 2'h0))
        else $error("write response wrong");

    cov_overflow: cover property (overflow ##1 overflow_irq);
    cov_capture: cover property (ev[1] && !is_out[1]);
    cov_link_swap: cover property (linked && overflow && st.last_wr && !st.active);
    cov_pwm_toggle: cover property (overflow && st.ch[0].tov && is_out[0]);

endmodule : tcc_top

// >>> verification/tcc_pin_model.sv
`timescale 1ns/1ps

module tcc_pin_model (
    input  wire logic aclk,     // Bus clock
    input  wire logic out0,     // Timer drive, pin 0
    input  wire logic oe0,      // Timer enable, pin 0
    input  wire logic out1,     // Timer drive, pin 1
    input  wire logic oe1,      // Timer enable, pin 1
    output logic      pin0,     // Wire level, pin 0
    output logic      pin1,     // Wire level, pin 1
    output logic      ext_clk   // External count clock
);
    logic drv0 = 1'b0;
    logic drv1 = 1'b0;
    initial ext_clk = 1'b0;
    // Timer wins the wire only while it drives
    assign pin0 = oe0 ? out0 : drv0;
    assign pin1 = oe1 ? out1 : drv1;
    task set_pin1(input logic v);
        @(posedge aclk);
        drv1 <= v;
    endtask : set_pin1
    // Clock stands still between bursts
    task pulses(input int n);
        repeat (n) begin
            @(posedge aclk);
            ext_clk <= 1'b1;
            repeat (2) @(posedge aclk);
            ext_clk <= 1'b0;
            @(posedge aclk);
        end
    endtask : pulses
endmodule : tcc_pin_model

// >>> verification/two_channel_capture_compare_timer_tb.sv
`timescale 1ns/1ps

module two_channel_capture_compare_timer_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, cnt, v;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, brk = 0;
    logic        awready, wready, bvalid, arready, rvalid, p0o, p0e, p1o, p1e, oirq, irq0, irq1;
    logic        pin0, pin1, extc;
    logic [1:0]  bresp, rresp, r;
    int          fails = 0, n_compared = 0, n, hi;
    bit          hit;

    tcc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chan0_pin_in(pin0),
        .chan0_pin_out(p0o), .chan0_pin_oe(p0e), .chan1_pin_in(pin1), .chan1_pin_out(p1o),
        .chan1_pin_oe(p1e), .external_timer_clock_pin(extc), .break_state(brk),
        .overflow_irq(oirq), .chan0_irq(irq0), .chan1_irq(irq1));
    tcc_pin_model u_pins (.aclk(aclk), .out0(p0o), .oe0(p0e), .out1(p1o), .oe1(p1e),
        .pin0(pin0), .pin1(pin1), .ext_clk(extc));

    // ----------------
    // Bus and checks
    // ----------------
    task stop_test;
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] x);
        bit pa, pw;
        pa = 1;
        pw = 1;
        @(posedge aclk);
        awaddr <= a; wdata <= x; awvalid <= 1; wvalid <= 1; bready <= 1;
        // Each channel released on its own handshake
        while (pa || pw) begin
            @(negedge aclk);
            if (awready) pa = 0;
            if (wready) pw = 0;
            @(posedge aclk);
            awvalid <= pa; wvalid <= pw;
        end
        do @(negedge aclk); while (!bvalid);
        r = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] x);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (!rvalid);
        x = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask : rd
    function automatic bit cap_hit(input int els, input bit rise);
        return els == 3 || (els == 1 && rise) || (els == 2 && !rise);
    endfunction : cap_hit
    // High time and period of pin 0, after two edges to settle
    task pw(output int h, output int p);
        repeat (2) begin
            do @(negedge aclk); while (p0o);
            do @(negedge aclk); while (!p0o);
        end
        p = 0;
        do begin @(negedge aclk); p++; end while (p0o);
        h = p;
        do begin @(negedge aclk); p++; end while (!p0o);
    endtask : pw

    initial forever #2 aclk = ~aclk;
    initial begin
        #100000;
        fails++;
        stop_test;
    end

    // ----------------
    // Scenarios
    // ----------------
    initial begin
        void'($urandom(32'h68937cf9));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rd(8'h00, d); chk(d, 32'h20);
        rd(8'h08, d); chk(d, 32'hffff);
        rd(8'h1c, d); chk({r, d[29:0]}, 32'h80000000);
        wr(8'h1c, 32'h1); chk(r, 2'h2);
        wr(8'h00, 32'h0);
        repeat ($urandom_range(500, 50)) @(posedge aclk);
        wr(8'h00, 32'h20);
        rd(8'h04, cnt);
        for (int els = 1; els < 4; els++) begin
            for (int rise = 0; rise < 2; rise++) begin
                u_pins.set_pin1(!rise);
                wr(8'h14, 32'hc0 | (els << 2));
                wr(8'h18, 32'hffff);
                u_pins.set_pin1(rise[0]);
                repeat (3) @(posedge aclk);
                hit = cap_hit(els, rise[0]);
                rd(8'h18, d); chk(d, hit ? cnt : 32'hffff);
                rd(8'h14, d); chk(d, (hit ? 32'hc0 : 32'h40) | (els << 2));
                chk(irq1, hit);
            end
        end
        chk(p1e, 1'b0);
        wr(8'h00, 32'h30);
        wr(8'h08, 32'hff);
        v = $urandom_range(253, 1);
        wr(8'h10, v);
        wr(8'h0c, 32'h9a);
        wr(8'h00, 32'h0);
        pw(hi, n);
        chk(hi, v);
        chk(n, 256);
        chk(p0e, 1'b1);
        rd(8'h00, d); chk(d, 32'h80);
        wr(8'h00, 32'h40); chk(oirq, 1'b1);
        // Raise right after overflow, lower right after a compare
        wr(8'h00, 32'hc0);
        do @(negedge aclk); while (!oirq);
        wr(8'h10, v + 1);
        pw(hi, n); chk(hi, v + 1);
        wr(8'h0c, 32'hda);
        do @(negedge aclk); while (!irq0);
        wr(8'h10, v);
        rd(8'h0c, d); chk({irq0, d[30:0]}, 32'h800000da);
        pw(hi, n); chk(hi, v);
        // Linked pair, set on compare: high from compare to overflow
        wr(8'h0c, 32'hae);
        chk({p1e, irq1}, 2'b00);
        pw(hi, n); chk(hi, 256 - v);
        wr(8'h18, v + 1);
        pw(hi, n); chk(hi, 255 - v);
        wr(8'h10, v);
        pw(hi, n); chk(hi, 256 - v);
        @(posedge aclk);
        brk <= 1;
        rd(8'h04, d);
        rd(8'h04, cnt); chk(cnt, d);
        @(posedge aclk);
        brk <= 0;
        wr(8'h00, 32'h37);
        wr(8'h00, 32'h07);
        n = $urandom_range(40, 5);
        u_pins.pulses(n);
        repeat (4) @(posedge aclk);
        rd(8'h04, d); chk(d, n);
        stop_test;
    end
endmodule : two_channel_capture_compare_timer_tb
